// ===== verilog/accel_regs.svh
`ifndef ACCEL_REGS_SVH
`define ACCEL_REGS_SVH

// register offsets
`define X_AXIS_UPPER_BYTE_OFS   8'h08
`define Y_AXIS_UPPER_BYTE_OFS   8'h09
`define Z_AXIS_UPPER_BYTE_OFS   8'h0a
`define DEVICE_STATUS_FLAGS_OFS 8'h0b

// full-resolution data register span
`define DATA_SPAN_LO_OFS 8'h0e
`define DATA_SPAN_HI_OFS 8'h17

// status field positions
`define STAT_ERR_BIT   7
`define STAT_AWAKE_BIT 6
`define STAT_STILLNESS_DETECTED_BIT 5
`define STAT_ACT_BIT   4
`define STAT_OVR_BIT   3
`define STAT_WM_BIT    2
`define STAT_RDY_BIT   1
`define STAT_DRDY_BIT  0

// reset values
`define AXIS_BYTE_RST   8'h00
`define STATUS_RST      8'h40
`define UNMAPPED_RDATA  8'h00

// upper byte of a 14-bit sample
`define SAMPLE_MSB 13
`define SAMPLE_LSB 6

// detector chain mode with no linking
`define CHAIN_MODE_DEFAULT 2'h0

`endif

// ===== verilog/accel_pkg.sv
package accel_pkg;

  typedef struct packed {
    logic [13:0] x;
    logic [13:0] y;
    logic [13:0] z;
  } sample_t;

  typedef struct packed {
    logic err;
    logic awake;
    logic stillness_detected;
    logic act;
    logic ovr;
    logic wm;
    logic rdy;
    logic drdy;
  } status_t;

  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
    status_t    status;
  } snapshot_t;

endpackage

// ===== verilog/accel_sample_status_regs.sv
`timescale 1ns/1ps
`include "accel_regs.svh"

// Overview of operation
// - x register at 0x08 holds bits 13..6 of latest x sample.
// - y register at 0x09 holds upper eight bits of latest y sample.
// - z register at 0x0a holds upper eight bits of latest z sample.
// - status bit 7 upset flag set at power-up, soft reset, register disturbance.
// - upset flag clears when any register write is carried out.
// - status bit 6 shows awake state, reset value 1.
// - awake bit held at 1 unless detectors linked or looped.
// - status bit 5 set on inactivity or free-fall detection.
// - status bit 4 set on activity above threshold.
// - status bit 3 on overflow; further queue writes blocked until a read.
// - overrun flag only produced in keep-oldest queue policy.
// - status bit 2 set when queue holds at least threshold samples.
// - watermark asserts on the write taking count to threshold or beyond.
// - status bit 1 set while queue holds a sample, else clear.
// - status bit 0 set on new sample, cleared by data read.
// - data-ready never set during a register read; deferred until read ends.
// - data-ready cleared at read start; late sample sets it after read.

module sample_fifo #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  wire              push;
  wire              pop;
  wire              wrap_wr;
  wire              wrap_rd;

  assign in_ready_o  = (count_q != (PW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign wrap_wr     = (wr_ptr_q == PW'(DEPTH - 1));
  assign wrap_rd     = (rd_ptr_q == PW'(DEPTH - 1));
  assign out_data_o  = mem_q[rd_ptr_q];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          mem_q[i] <= '0;
        end else if (push && wr_ptr_q == PW'(i)) begin
          mem_q[i] <= in_data_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wrap_wr ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= wrap_rd ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module accel_sample_status_regs #(
  parameter int FIFO_DEPTH = 8,
  parameter int CNT_W      = 10
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  nrst_i,
  input  wire logic                  sample_valid_i,
  output logic                       sample_ready_o,
  input  wire accel_pkg::sample_t    sample_i,
  input  wire logic                  soft_rst_i,
  input  wire logic                  upset_i,
  input  wire logic                  awake_i,
  input  wire logic [1:0]            detector_chain_mode_i,
  input  wire logic                  stillness_detected_i,
  input  wire logic                  motion_detected_i,
  input  wire logic                  queue_oldest_mode_i,
  input  wire logic                  queue_overflow_i,
  input  wire logic                  queue_wr_i,
  input  wire logic                  queue_rd_i,
  input  wire logic [CNT_W-1:0]      queue_count_i,
  input  wire logic [CNT_W-1:0]      queue_threshold_i,
  output logic                       queue_wr_block_o,
  input  wire logic                  clk_link_i,
  input  wire logic                  link_rd_frame_i,
  input  wire logic                  link_rd_i,
  input  wire logic                  link_wr_i,
  input  wire logic [7:0]            link_addr_i,
  output logic      [7:0]            link_rdata_o
);
  // link-domain state, declared ahead of the system side that samples it
  logic                 frame_link_q;
  logic                 wr_tog_q;
  logic                 req_meta_q;
  logic                 req_sync_q;
  logic                 ack_q;
  accel_pkg::snapshot_t shadow_q;
  logic [7:0]           rdata_q;
  logic [7:0]           rdata_d;

  // ---------------- system domain ----------------
  logic                 frame_meta_q;
  logic                 frame_sync_q;
  logic                 frame_prev_q;
  logic                 wr_meta_q;
  logic                 wr_sync_q;
  logic                 wr_prev_q;
  logic                 ack_meta_q;
  logic                 ack_sync_q;
  logic                 req_q;
  accel_pkg::snapshot_t snap_q;
  logic [7:0]           x_q;
  logic [7:0]           y_q;
  logic [7:0]           z_q;
  accel_pkg::status_t   stat_q;
  accel_pkg::status_t   stat_d;
  logic                 pending_q;
  logic                 pending_d;
  logic                 fifo_valid;
  accel_pkg::sample_t   fifo_data;
  logic [41:0]          fifo_raw;
  accel_pkg::snapshot_t snap_d;

  // control decode
  wire                  frame_rise;
  wire                  wr_pulse;
  wire                  pub_busy;
  wire                  pub_go;
  wire                  drain_ok;
  wire                  take_sample;
  wire                  chain_on;
  wire                  wm_reach;
  wire                  ovr_set;
  wire                  err_set;

  // next values of the plain status fields
  wire                  err_next;
  wire                  ovr_next;
  wire                  awake_next;
  wire                  rdy_next;
  wire                  wm_clear;
  wire                  wm_set;

  assign frame_rise  = frame_sync_q & ~frame_prev_q;
  assign wr_pulse    = wr_sync_q ^ wr_prev_q;
  assign pub_busy    = req_q ^ ack_sync_q;
  assign pub_go      = ~pub_busy & ~frame_sync_q;
  assign drain_ok    = ~frame_sync_q;
  assign take_sample = fifo_valid & drain_ok;
  assign chain_on    = (detector_chain_mode_i != `CHAIN_MODE_DEFAULT);
  assign wm_reach    = (queue_count_i >= queue_threshold_i);
  assign ovr_set     = queue_overflow_i & queue_oldest_mode_i;
  assign err_set     = soft_rst_i | upset_i;

  // set wins over clear for both sticky flags
  assign err_next    = err_set | (stat_q.err & ~wr_pulse);
  assign ovr_next    = ovr_set | (stat_q.ovr & ~queue_rd_i);
  assign awake_next  = chain_on ? awake_i : 1'b1;
  assign rdy_next    = (queue_count_i != '0);
  assign wm_clear    = ~wm_reach;
  assign wm_set      = wm_reach & queue_wr_i;

  // one coherent picture of all four registers
  assign snap_d = '{x: x_q, y: y_q, z: z_q, status: stat_q};

  assign fifo_data = accel_pkg::sample_t'(fifo_raw);

  sample_fifo #(
    .WIDTH (42),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .in_data_i   (sample_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (drain_ok),
    .out_data_o  (fifo_raw)
  );

  // read frame level into the system clock
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_meta_q <= 1'b0;
      frame_sync_q <= 1'b0;
      frame_prev_q <= 1'b0;
    end else begin
      frame_meta_q <= frame_link_q;
      frame_sync_q <= frame_meta_q;
      frame_prev_q <= frame_sync_q;
    end
  end

  // write toggle into the system clock
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_meta_q <= 1'b0;
      wr_sync_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      wr_meta_q <= wr_tog_q;
      wr_sync_q <= wr_meta_q;
      wr_prev_q <= wr_sync_q;
    end
  end

  // publish acknowledge back from the link side
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
    end else begin
      ack_meta_q <= ack_q;
      ack_sync_q <= ack_meta_q;
    end
  end

  // axis bytes, one sample at a time
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      x_q <= `AXIS_BYTE_RST;
      y_q <= `AXIS_BYTE_RST;
      z_q <= `AXIS_BYTE_RST;
    end else if (take_sample) begin
      x_q <= fifo_data.x[`SAMPLE_MSB:`SAMPLE_LSB];
      y_q <= fifo_data.y[`SAMPLE_MSB:`SAMPLE_LSB];
      z_q <= fifo_data.z[`SAMPLE_MSB:`SAMPLE_LSB];
    end
  end

  always_comb begin
    stat_d       = stat_q;
    pending_d    = pending_q | take_sample;
    stat_d.err   = err_next;
    stat_d.awake = awake_next;
    stat_d.stillness_detected = stillness_detected_i;
    stat_d.act   = motion_detected_i;
    stat_d.ovr   = ovr_next;
    if (wm_clear) begin
      stat_d.wm = 1'b0;
    end else if (wm_set) begin
      stat_d.wm = 1'b1;
    end
    stat_d.rdy = rdy_next;
    if (frame_rise) begin
      stat_d.drdy = 1'b0;
    end else if (pending_d && !frame_sync_q) begin
      stat_d.drdy = 1'b1;
      pending_d   = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_q    <= accel_pkg::status_t'(`STATUS_RST);
      stat_q.err <= 1'b1;
      pending_q <= 1'b0;
    end else begin
      stat_q    <= stat_d;
      pending_q <= pending_d;
    end
  end

  assign queue_wr_block_o = stat_q.ovr;

  // snapshot published to the link side, held while in flight
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      snap_q <= '0;
      req_q  <= 1'b0;
    end else if (pub_go) begin
      snap_q <= snap_d;
      req_q  <= ~req_q;
    end
  end

  // ---------------- link domain ----------------
  wire                  accept;

  // a new snapshot lands only between read frames
  assign accept = (req_sync_q ^ ack_q) & ~link_rd_frame_i & ~frame_link_q;

  always_comb begin
    unique case (link_addr_i)
      `X_AXIS_UPPER_BYTE_OFS:   rdata_d = shadow_q.x;
      `Y_AXIS_UPPER_BYTE_OFS:   rdata_d = shadow_q.y;
      `Z_AXIS_UPPER_BYTE_OFS:   rdata_d = shadow_q.z;
      `DEVICE_STATUS_FLAGS_OFS: rdata_d = shadow_q.status;
      default:                  rdata_d = `UNMAPPED_RDATA;
    endcase
  end

  // frame level and write toggle, launched from flops
  always_ff @(posedge clk_link_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_link_q <= 1'b0;
      wr_tog_q     <= 1'b0;
    end else begin
      frame_link_q <= link_rd_frame_i;
      wr_tog_q     <= wr_tog_q ^ link_wr_i;
    end
  end

  // publish request into the link clock
  always_ff @(posedge clk_link_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= req_q;
      req_sync_q <= req_meta_q;
    end
  end

  // shadow frozen for the whole read frame
  always_ff @(posedge clk_link_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shadow_q <= '{x: `AXIS_BYTE_RST, y: `AXIS_BYTE_RST, z: `AXIS_BYTE_RST,
                    status: accel_pkg::status_t'(`STATUS_RST)};
      ack_q    <= 1'b0;
    end else if (accept) begin
      shadow_q <= snap_q;
      ack_q    <= req_sync_q;
    end
  end

  always_ff @(posedge clk_link_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= `UNMAPPED_RDATA;
    end else if (link_rd_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign link_rdata_o = rdata_q;
endmodule

// ===== test/accel_regs_props.sv
`timescale 1ns/1ps
module accel_regs_props (
  input wire logic       clk_sys_i,
  input wire logic       clk_link_i,
  input wire logic       nrst_i,
  input wire logic       queue_oldest_mode_i,
  input wire logic       queue_overflow_i,
  input wire logic       queue_rd_i,
  input wire logic       queue_wr_block_o,
  input wire logic       link_rd_i,
  input wire logic [7:0] link_addr_i,
  input wire logic [7:0] link_rdata_o
);
  wire ov    = queue_oldest_mode_i && queue_overflow_i;
  wire unmap = link_addr_i < 8'h08 || link_addr_i > 8'h0b;
  ovr_set_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ov |=> queue_wr_block_o) else $error("overrun not set");
  ovr_keep_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $fell(queue_wr_block_o) |-> $past(queue_rd_i)) else $error("overrun dropped");
  ovr_clear_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    queue_wr_block_o && queue_rd_i && !ov |=> !queue_wr_block_o) else $error("overrun kept");
  ovr_wins_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    queue_wr_block_o && queue_rd_i && ov |=> queue_wr_block_o) else $error("set lost");
  ovr_mode_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(queue_wr_block_o) |-> $past(ov)) else $error("overrun uncaused");
  ovr_idle_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !queue_oldest_mode_i && !queue_wr_block_o |=> !queue_wr_block_o) else $error("overrun in mode");
  unmap_rd_a: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
    link_rd_i && unmap ##1 !link_rd_i |-> ##1 link_rdata_o == 8'h00) else $error("unmapped data");
  rdata_hold_a: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
    !$stable(link_rdata_o) |-> $past(link_rd_i) || $past(link_rd_i, 2)) else $error("data moved");
  ovr_c: cover property (@(posedge clk_sys_i) ov);
  unmap_c: cover property (@(posedge clk_link_i) link_rd_i && unmap);
  stat_c: cover property (@(posedge clk_link_i) link_rd_i && link_addr_i == 8'h0b);
endmodule

// ===== test/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            frm_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic      [7:0] addr_o
);
  initial begin
    frm_o = 0;
    rd_o = 0;
    wr_o = 0;
    addr_o = 8'h00;
  end
  task frame(input logic f);
    @(posedge clk_i);
    frm_o <= f;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_o <= 1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 0;
    addr_o <= ~a;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask
  task wr();
    @(posedge clk_i);
    wr_o <= 1;
    @(posedge clk_i);
    wr_o <= 0;
  endtask
endmodule

// ===== test/accel_sample_status_regs_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module accel_sample_status_regs_tb;
  logic clk_sys_i = 0, clk_link_i = 0, nrst_i = 0, sample_valid_i = 0, soft_rst_i = 0, upset_i = 0;
  logic awake_i = 1, stillness_detected_i = 0, motion_detected_i = 0, queue_oldest_mode_i = 0;
  logic queue_overflow_i = 0, queue_wr_i = 0, queue_rd_i = 0, xov = 0, xwm = 0, ok;
  logic [1:0] detector_chain_mode_i = 2'h0;
  logic [9:0] queue_count_i = 10'h000, queue_threshold_i = 10'h003;
  logic [7:0] d, um [6] = '{8'h08, 8'h09, 8'h0a, 8'h00, 8'h0c, 8'hff};
  logic [31:0] r = 32'h5249, v;
  logic [3:0] na;
  int n_errors = 0, total_checks = 0;
  accel_pkg::sample_t sample_i = '0, s, n;
  wire logic sample_ready_o, queue_wr_block_o, link_rd_frame_i, link_rd_i, link_wr_i;
  wire logic [7:0] link_addr_i, link_rdata_o;
  always #12.5 clk_sys_i = ~clk_sys_i;
  always #24 clk_link_i = ~clk_link_i;
  accel_sample_status_regs i_accel_sample_status_regs (.*);
  host_model i_host_model (.clk_i(clk_link_i), .rdata_i(link_rdata_o), .frm_o(link_rd_frame_i),
    .rd_o(link_rd_i), .wr_o(link_wr_i), .addr_o(link_addr_i));
  function automatic logic [31:0] nx();
    r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    return r;
  endfunction
  function automatic accel_pkg::sample_t smp();
    logic [63:0] t;
    t = {nx(), nx()};
    return t[41:0];
  endfunction
  function automatic logic [7:0] st(input logic e, input logic dr);
    return {e, detector_chain_mode_i == 2'h0 || awake_i, stillness_detected_i, motion_detected_i,
            xov, xwm, queue_count_i != 10'h000, dr};
  endfunction
  task cyc(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  task automatic pulse(ref logic p);
    @(negedge clk_sys_i);
    p = 1;
    @(negedge clk_sys_i);
    p = 0;
  endtask
  task push(input accel_pkg::sample_t x);
    @(negedge clk_sys_i);
    sample_i = x;
    sample_valid_i = 1;
    ok = sample_ready_o;
    @(negedge clk_sys_i);
    sample_valid_i = 0;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    i_host_model.rd(a, d);
    `CHK($sformatf("reg %h", a), e, d)
  endtask
  task fst(input logic e);
    i_host_model.frame(1);
    rdc(8'h0b, st(e, 0));
    i_host_model.frame(0);
  endtask
  task frd();
    i_host_model.frame(1);
    rdc(8'h0b, st(0, 1));
    rdc(8'h08, s.x[13:6]);
    rdc(8'h09, s.y[13:6]);
    rdc(8'h0a, s.z[13:6]);
    i_host_model.frame(0);
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge clk_sys_i);
    n_errors++;
    test_done();
  end
  initial begin
    cyc(3);
    nrst_i = 1;
    cyc(40);
    fst(1);
    i_host_model.frame(1);
    foreach (um[i]) rdc(um[i], 8'h00);
    i_host_model.frame(0);
    $display("reset test done");
    for (int k = 0; k < 2; k++) begin
      i_host_model.wr();
      cyc(40);
      fst(0);
      if (k == 0) pulse(soft_rst_i);
      else pulse(upset_i);
      cyc(40);
      fst(1);
    end
    i_host_model.wr();
    $display("upset test done");
    repeat (6) begin
      v = nx();
      cyc(1);
      {detector_chain_mode_i, awake_i, stillness_detected_i, motion_detected_i} = v[4:0];
      cyc(40);
      fst(0);
    end
    $display("detector test done");
    for (int k = 2; k < 5; k++) begin
      cyc(1);
      queue_count_i = (k == 4) ? 10'h000 : 10'(k);
      v = nx();
      queue_threshold_i = 10'(2 + v % 3);
      xwm = queue_count_i >= queue_threshold_i;
      pulse(queue_wr_i);
      cyc(40);
      fst(0);
    end
    for (int k = 0; k < 2; k++) begin
      cyc(1);
      queue_oldest_mode_i = k[0];
      pulse(queue_overflow_i);
      xov = k[0];
      `CHK("block", xov, queue_wr_block_o)
    end
    cyc(40);
    fst(0);
    {queue_overflow_i, queue_rd_i} = 2'b11;
    cyc(1);
    {queue_overflow_i, queue_rd_i} = 2'b00;
    `CHK("block", 1'b1, queue_wr_block_o)
    pulse(queue_rd_i);
    `CHK("block", 1'b0, queue_wr_block_o)
    xov = 0;
    queue_oldest_mode_i = 0;
    $display("queue flag test done");
    s = smp();
    push(s);
    repeat (3) begin
      cyc(40);
      frd();
      cyc(40);
      i_host_model.frame(1);
      cyc(6);
      n = smp();
      push(n);
      cyc(40);
      rdc(8'h0b, st(0, 0));
      rdc(8'h08, s.x[13:6]);
      i_host_model.frame(0);
      s = n;
    end
    $display("data ready test done");
    i_host_model.frame(1);
    cyc(6);
    na = 0;
    repeat (10) begin
      n = smp();
      push(n);
      if (ok) begin
        na++;
        s = n;
      end
    end
    `CHK("accepted", 4'h8, na)
    i_host_model.frame(0);
    cyc(80);
    frd();
    $display("buffer test done");
    test_done();
  end
endmodule
bind accel_sample_status_regs accel_regs_props i_accel_regs_props (.*);
